// ===== hw/adc_seq_defs.svh
// register offsets, field positions, reset values and timing counts of the converter control
// assumes a 32-bit classic wishbone slave with byte addresses and one word per register
// How it works
// - each conversion yields an unsigned ten-bit code from the successive-approximation core
// - fastest setting, one acquisition clock plus twelve, reaches five hundred ksps
// - any of sixteen inputs routes to hold channel zero, channels one to three pick from four settings; all feed one core
// - a control bit picks supply pair or external reference pins
// - sequencing ignores the device sleep state and keeps converting
// - six sixteen-bit software registers: three controls, input, pin and scan select
// - input-select register picks the inputs connected to the hold channels
// - each pin-configuration bit makes its pin analog or digital
// - scan-select register marks inputs taking part in automatic scanning
// - sixteen-entry result buffer, readable while conversions write it
// - entries hold ten bits, read back as a formatted sixteen-bit word
// - software writes to result entries have no effect
// - each result is stored; flag and done rise after the programmed sample count
// - trigger 000 starts on sample bit clear; 111 after auto sample time
// - turning off aborts without storing, beats auto start; two clock wait after
// - a conversion takes twelve conversion clocks of (divider plus one) half cycles
`ifndef ADC_SEQ_DEFS_SVH
`define ADC_SEQ_DEFS_SVH

// ----------------------------------------------------------------
// word indices (byte address is four times the index)
// ----------------------------------------------------------------
`define ADC_IDX_CTRL1 6'h10
`define ADC_IDX_CTRL2 6'h11
`define ADC_IDX_CTRL3 6'h12
`define ADC_IDX_ISEL 6'h13
`define ADC_IDX_PCFG 6'h14
`define ADC_IDX_SCAN 6'h15
`define ADC_IDX_STATUS 6'h16
`define ADC_IDX_CLEAR 6'h17
`define ADC_IDX_ENABLE 6'h18

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define ADC_C1_ON 15
`define ADC_C1_FORM_HI 9
`define ADC_C1_FORM_LO 8
`define ADC_C1_TRIG_HI 7
`define ADC_C1_TRIG_LO 5
`define ADC_C1_SIMULTANEOUS_SAMPLE 3
`define ADC_C1_AUTO 2
`define ADC_C1_SAMPLE_BIT 1
`define ADC_C1_DONE 0
`define ADC_C2_REFEXT 13
`define ADC_C2_SCAN 10
`define ADC_C2_CHPS_HI 9
`define ADC_C2_CHPS_LO 8
`define ADC_C2_HALF 7
`define ADC_C2_SMPI_HI 5
`define ADC_C2_SMPI_LO 2
`define ADC_C2_SPLIT 1
`define ADC_C2_ALTERNATE_MUX_SEL 0
`define ADC_ST_DONE 0
`define ADC_ST_ABORT 1

// ----------------------------------------------------------------
// values and counts
// ----------------------------------------------------------------
`define ADC_RST16 16'h0000
`define ADC_TRIG_SOFT 3'h0
`define ADC_TRIG_AUTO 3'h7
`define ADC_DAC_START 10'h200
`define ADC_TAD_LAST 4'hb
`define ADC_HOLDOFF_TAD 2'h2
`define ADC_HALF_BASE 4'h8

`endif

// ===== hw/adc_seq_pkg.sv
// types shared by the converter control: sequencer states and the state record
// assumes the constants header for widths of fields
package adc_seq_pkg;

    typedef enum logic [1:0] {
        seq_idle,
        seq_sample,
        seq_convert
    } seq_e;

    typedef struct packed {
        logic ack;
        logic [31:0] rdata;
        logic [15:0] ctrl1;
        logic [15:0] ctrl2;
        logic [15:0] ctrl3;
        logic [15:0] isel;
        logic [15:0] pcfg;
        logic [15:0] scan;
        logic [1:0] irq_en;
        logic [1:0] status;
        logic irq;
        logic [15:0][9:0] results;
        logic [3:0] wptr;
        logic half;
        logic [3:0] seq_cnt;
        logic [1:0] sh_ch;
        logic use_b;
        logic [3:0] scan_pos;
        seq_e state;
        logic [6:0] acc;
        logic [3:0] tad_cnt;
        logic [4:0] sample_bit_cnt;
        logic [1:0] holdoff;
        logic [9:0] code;
        logic buf_wr;
        logic irq_evt;
        logic done;
        logic sample_out;
        logic [3:0] ch0_sel;
        logic [1:0] ch123_sel;
        logic ref_ext;
        logic [15:0] pin_analog;
    } state_s;

endpackage

// ===== hw/sar_adc_sequencer.sv
// converter control: wishbone register file, conversion clock, sampling sequencer,
// successive-approximation loop and sixteen-entry result buffer
// assumes an analog front end with a comparator and a ten-bit dac driven from here
`timescale 1ns/10ps
`default_nettype none
`include "adc_seq_defs.svh"

module sar_adc_sequencer (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    output logic irq_o,
    input wire logic comparator_i,
    input wire logic trigger_i,
    output logic [9:0] dac_code_o,
    output logic sample_o,
    output logic [1:0] sh_channel_o,
    output logic [3:0] ch0_input_o,
    output logic [1:0] ch123_input_o,
    output logic ref_ext_o,
    output logic [15:0] analog_pin_en_o
);

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    function automatic logic [15:0] lane_write(input logic [15:0] old, input logic [31:0] d,
                                               input logic [3:0] sel);
        lane_write = {sel[1] ? d[15:8] : old[15:8], sel[0] ? d[7:0] : old[7:0]};
    endfunction

    // lowest marked input at or above from; zero when none is marked
    function automatic logic [3:0] scan_from(input logic [15:0] mask, input logic [4:0] from);
        scan_from = 4'h0;
        for (int i = 15; i >= 0; i--) begin
            if (mask[i] && (5'(i) >= from)) begin
                scan_from = 4'(i);
            end
        end
    endfunction

    function automatic logic [15:0] fmt(input logic [9:0] c, input logic [1:0] form);
        case (form)
            2'h0: fmt = {6'h00, c};
            2'h1: fmt = {{7{~c[9]}}, c[8:0]};
            2'h2: fmt = {c, 6'h00};
            default: fmt = {~c[9], c[8:0], 6'h00};
        endcase
    endfunction

    adc_seq_pkg::state_s st;
    adc_seq_pkg::state_s n;
    logic req;
    logic [5:0] idx;
    logic on;
    logic tick;
    logic fire;
    logic [6:0] div1;
    logic [6:0] sum;
    logic [2:0] nch;
    logic [4:0] ast;

    assign req = wb_cyc_i && wb_stb_i && !st.ack;
    assign idx = wb_adr_i[7:2];

    always_comb begin
        n = st;
        n.buf_wr = 1'b0;
        n.irq_evt = 1'b0;
        fire = 1'b0;
        tick = 1'b0;
        // ----------------------------------------------------------------
        // bus slave: one-cycle registered answer, unmapped reads give zero
        // ----------------------------------------------------------------
        n.ack = req;
        if (req) begin
            n.rdata = 32'h0000_0000;
            if (idx < 6'h10) begin
                n.rdata[15:0] = fmt(st.results[idx[3:0]],
                                    st.ctrl1[`ADC_C1_FORM_HI:`ADC_C1_FORM_LO]);
            end else begin
                case (idx)
                    `ADC_IDX_CTRL1: n.rdata[15:0] = {st.ctrl1[15:1], st.done};
                    `ADC_IDX_CTRL2: n.rdata[15:0] = {st.ctrl2[15:8], st.half, st.ctrl2[6:0]};
                    `ADC_IDX_CTRL3: n.rdata[15:0] = st.ctrl3;
                    `ADC_IDX_ISEL: n.rdata[15:0] = st.isel;
                    `ADC_IDX_PCFG: n.rdata[15:0] = st.pcfg;
                    `ADC_IDX_SCAN: n.rdata[15:0] = st.scan;
                    `ADC_IDX_STATUS: n.rdata[1:0] = st.status;
                    `ADC_IDX_ENABLE: n.rdata[1:0] = st.irq_en;
                    default: n.rdata = 32'h0000_0000;
                endcase
            end
        end
        // result entries are absent from this case, so buffer writes fall away
        if (req && wb_we_i) begin
            case (idx)
                `ADC_IDX_CTRL1: n.ctrl1 = lane_write(st.ctrl1, wb_dat_i, wb_sel_i);
                `ADC_IDX_CTRL2: n.ctrl2 = lane_write(st.ctrl2, wb_dat_i, wb_sel_i);
                `ADC_IDX_CTRL3: n.ctrl3 = lane_write(st.ctrl3, wb_dat_i, wb_sel_i);
                `ADC_IDX_ISEL: n.isel = lane_write(st.isel, wb_dat_i, wb_sel_i);
                `ADC_IDX_PCFG: n.pcfg = lane_write(st.pcfg, wb_dat_i, wb_sel_i);
                `ADC_IDX_SCAN: n.scan = lane_write(st.scan, wb_dat_i, wb_sel_i);
                `ADC_IDX_CLEAR: n.status = st.status & ~(wb_sel_i[0] ? wb_dat_i[1:0] : 2'h0);
                `ADC_IDX_ENABLE: n.irq_en = wb_sel_i[0] ? wb_dat_i[1:0] : st.irq_en;
                default: n.irq_en = n.irq_en;
            endcase
        end
        // ----------------------------------------------------------------
        // conversion clock: phase accumulator in half instruction cycles
        // ----------------------------------------------------------------
        // sleep has no input here on purpose: the sequencer never stops for it
        on = n.ctrl1[`ADC_C1_ON];
        div1 = {1'b0, st.ctrl3[5:0]} + 7'h01;
        sum = st.acc + 7'h02;
        nch = (st.ctrl2[`ADC_C2_CHPS_HI:`ADC_C2_CHPS_LO] == 2'h0) ? 3'h1 :
              (st.ctrl2[`ADC_C2_CHPS_HI:`ADC_C2_CHPS_LO] == 2'h1) ? 3'h2 : 3'h4;
        ast = (st.ctrl3[12:8] == 5'h00) ? 5'h01 : st.ctrl3[12:8];
        if (!on) begin
            // an abort leaves results and pointer as they were
            if (st.state != adc_seq_pkg::seq_idle) begin
                n.status[`ADC_ST_ABORT] = 1'b1;
                n.holdoff = `ADC_HOLDOFF_TAD;
            end
            n.state = adc_seq_pkg::seq_idle;
            n.acc = 7'h00;
            n.tad_cnt = 4'h0;
            n.sh_ch = 2'h0;
            n.holdoff = (st.state != adc_seq_pkg::seq_idle) ? `ADC_HOLDOFF_TAD : st.holdoff;
        end else begin
            // a divider at or below one clamps to one conversion clock per cycle
            if (div1 <= 7'h02) begin
                tick = 1'b1;
                n.acc = 7'h00;
            end else if (sum >= div1) begin
                tick = 1'b1;
                n.acc = sum - div1;
            end else begin
                n.acc = sum;
            end
            if (tick && (st.holdoff != 2'h0)) begin
                n.holdoff = st.holdoff - 2'h1;
            end
            // ----------------------------------------------------------------
            // sequencer
            // ----------------------------------------------------------------
            case (st.state)
                adc_seq_pkg::seq_idle: begin
                    if (n.ctrl1[`ADC_C1_SAMPLE_BIT] && (st.holdoff == 2'h0)) begin
                        n.state = adc_seq_pkg::seq_sample;
                        n.sample_bit_cnt = 5'h00;
                    end
                end
                adc_seq_pkg::seq_sample: begin
                    case (st.ctrl1[`ADC_C1_TRIG_HI:`ADC_C1_TRIG_LO])
                        `ADC_TRIG_SOFT: fire = !n.ctrl1[`ADC_C1_SAMPLE_BIT];
                        `ADC_TRIG_AUTO: begin
                            if (tick) begin
                                if (st.sample_bit_cnt + 5'h01 >= ast) begin
                                    fire = 1'b1;
                                end else begin
                                    n.sample_bit_cnt = st.sample_bit_cnt + 5'h01;
                                end
                            end
                        end
                        default: fire = trigger_i;
                    endcase
                    if (fire) begin
                        n.state = adc_seq_pkg::seq_convert;
                        n.ctrl1[`ADC_C1_SAMPLE_BIT] = 1'b0;
                        n.tad_cnt = 4'h0;
                        n.done = 1'b0;
                    end
                end
                adc_seq_pkg::seq_convert: begin
                    if (tick) begin
                        n.tad_cnt = st.tad_cnt + 4'h1;
                        if (st.tad_cnt == 4'h0) begin
                            n.code = `ADC_DAC_START;
                        end else if (st.tad_cnt <= 4'ha) begin
                            // keep the trial bit if the input is at or above the dac level
                            n.code[4'ha - st.tad_cnt] = comparator_i;
                            if (st.tad_cnt != 4'ha) begin
                                n.code[4'h9 - st.tad_cnt] = 1'b1;
                            end
                        end else begin
                            n.results[st.wptr] = st.code;
                            n.buf_wr = 1'b1;
                            n.wptr = st.wptr + 4'h1;
                            n.tad_cnt = 4'h0;
                            if ({1'b0, st.sh_ch} + 3'h1 < nch) begin
                                n.sh_ch = st.sh_ch + 2'h1;
                                if (st.ctrl1[`ADC_C1_SIMULTANEOUS_SAMPLE]) begin
                                    n.state = adc_seq_pkg::seq_convert;
                                end else begin
                                    n.state = adc_seq_pkg::seq_sample;
                                    n.sample_bit_cnt = 5'h00;
                                    n.ctrl1[`ADC_C1_SAMPLE_BIT] = 1'b1;
                                end
                            end else begin
                                n.sh_ch = 2'h0;
                                n.use_b = st.ctrl2[`ADC_C2_ALTERNATE_MUX_SEL] ? ~st.use_b : 1'b0;
                                n.scan_pos = scan_from(st.scan, {1'b0, st.scan_pos} + 5'h01);
                                if (st.seq_cnt == st.ctrl2[`ADC_C2_SMPI_HI:`ADC_C2_SMPI_LO]) begin
                                    n.irq_evt = 1'b1;
                                    n.status[`ADC_ST_DONE] = 1'b1;
                                    n.done = 1'b1;
                                    n.seq_cnt = 4'h0;
                                    n.use_b = 1'b0;
                                    n.scan_pos = scan_from(st.scan, 5'h00);
                                    n.half = st.ctrl2[`ADC_C2_SPLIT] ? ~st.half : 1'b0;
                                    n.wptr = (st.ctrl2[`ADC_C2_SPLIT] && !st.half) ?
                                             `ADC_HALF_BASE : 4'h0;
                                end else begin
                                    n.seq_cnt = st.seq_cnt + 4'h1;
                                end
                                if (st.ctrl1[`ADC_C1_AUTO]) begin
                                    n.state = adc_seq_pkg::seq_sample;
                                    n.sample_bit_cnt = 5'h00;
                                    n.ctrl1[`ADC_C1_SAMPLE_BIT] = 1'b1;
                                end else begin
                                    n.state = adc_seq_pkg::seq_idle;
                                end
                            end
                        end
                    end
                end
                default: n.state = adc_seq_pkg::seq_idle;
            endcase
        end
        // ----------------------------------------------------------------
        // front-end drive and interrupt
        // ----------------------------------------------------------------
        n.sample_out = (n.state == adc_seq_pkg::seq_sample);
        n.ch0_sel = (st.ctrl2[`ADC_C2_SCAN] && !n.use_b) ? n.scan_pos :
                    (n.use_b ? st.isel[11:8] : st.isel[3:0]);
        n.ch123_sel = n.use_b ? st.isel[13:12] : st.isel[5:4];
        n.ref_ext = st.ctrl2[`ADC_C2_REFEXT];
        n.pin_analog = ~st.pcfg;
        n.irq = |(n.status & n.irq_en);
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st <= '0;
        end else begin
            st <= n;
        end
    end

    assign wb_dat_o = st.rdata;
    assign wb_ack_o = st.ack;
    assign irq_o = st.irq;
    assign dac_code_o = st.code;
    assign sample_o = st.sample_out;
    assign sh_channel_o = st.sh_ch;
    assign ch0_input_o = st.ch0_sel;
    assign ch123_input_o = st.ch123_sel;
    assign ref_ext_o = st.ref_ext;
    assign analog_pin_en_o = st.pin_analog;

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    ack_pulse_a: assert property (@(posedge clk_i) disable iff (rst_i)
        st.ack |=> !st.ack) else $error("ack held longer than one cycle");
    ack_reply_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (wb_cyc_i && wb_stb_i && !st.ack) |=> st.ack) else $error("request not answered");
    buffer_readonly_a: assert property (@(posedge clk_i) disable iff (rst_i)
        !st.buf_wr |-> st.results == $past(st.results)) else $error("buffer changed without result");
    abort_no_store_a: assert property (@(posedge clk_i) disable iff (rst_i)
        !st.ctrl1[`ADC_C1_ON] |-> (!st.buf_wr && st.state == adc_seq_pkg::seq_idle))
        else $error("store or activity while off");
    twelve_clocks_a: assert property (@(posedge clk_i) disable iff (rst_i)
        st.buf_wr |-> $past(st.tad_cnt) == `ADC_TAD_LAST) else $error("conversion length wrong");
    pointer_restart_a: assert property (@(posedge clk_i) disable iff (rst_i)
        st.irq_evt |-> (st.wptr == (st.half ? `ADC_HALF_BASE : 4'h0)))
        else $error("pointer not restarted");
    irq_flag_a: assert property (@(posedge clk_i) disable iff (rst_i)
        st.irq_evt |-> (st.buf_wr && st.done && st.status[`ADC_ST_DONE]))
        else $error("flag not raised with last result");
    soft_start_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (st.state == adc_seq_pkg::seq_sample && n.ctrl1[`ADC_C1_ON] && !n.ctrl1[`ADC_C1_SAMPLE_BIT]
         && st.ctrl1[`ADC_C1_TRIG_HI:`ADC_C1_TRIG_LO] == `ADC_TRIG_SOFT)
        |=> (st.state == adc_seq_pkg::seq_convert))
        else $error("software trigger missed");

endmodule
`default_nettype wire

// ===== hw/unused_placeholder_none.sv
// empty on purpose: all logic of the converter control sits in one design file
// assumes nothing of its surroundings
`timescale 1ns/10ps
`default_nettype none
`default_nettype wire

// ===== tb/analog_front_model.sv
// behavioural analog front end: one hold channel and a comparator against the trial code
// assumes the sequencer raises sample_i while the hold capacitor tracks the input
`timescale 1ns/10ps
`default_nettype none

module analog_front_model (
    input wire logic clk_i,
    input wire logic sample_i,
    input wire logic [9:0] dac_code_i,
    input wire logic [9:0] level_i,
    output logic comparator_o
);
    // ----------------------------------------------------------------
    // hold and compare
    // ----------------------------------------------------------------
    logic [9:0] held;

    initial held = 10'h000;
    // a trial code equal to the held level counts as below it, so the code settles on the level
    always @(posedge clk_i) begin
        if (sample_i) begin
            held <= level_i;
        end
    end
    assign comparator_o = (held >= dac_code_i);
endmodule

`default_nettype wire

// ===== tb/tb_sar_adc_sequencer.sv
// self-checking bench of the converter control: register bus, soft and auto conversions,
// abort, interrupt masking and result buffer pointer
// assumes the analog front model answers the comparator input
`timescale 1ns/10ps
`default_nettype none
`include "adc_seq_defs.svh"

module tb_sar_adc_sequencer;
    logic clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, trigger_i, comparator_i;
    logic [7:0] wb_adr_i;
    logic [3:0] wb_sel_i;
    logic [31:0] wb_dat_i, wb_dat_o, q, r;
    logic wb_ack_o, irq_o, sample_o, ref_ext_o;
    logic [9:0] dac_code_o, level, lv, lv_b;
    logic [1:0] sh_channel_o, ch123_input_o;
    logic [3:0] ch0_input_o;
    logic [15:0] analog_pin_en_o;
    integer seed, n_mismatch, comparisons, n;

    sar_adc_sequencer dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
        .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
        .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .irq_o(irq_o),
        .comparator_i(comparator_i), .trigger_i(trigger_i), .dac_code_o(dac_code_o),
        .sample_o(sample_o), .sh_channel_o(sh_channel_o), .ch0_input_o(ch0_input_o),
        .ch123_input_o(ch123_input_o), .ref_ext_o(ref_ext_o),
        .analog_pin_en_o(analog_pin_en_o));
    analog_front_model front (.clk_i(clk_i), .sample_i(sample_o), .dac_code_i(dac_code_o),
        .level_i(level), .comparator_o(comparator_i));

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    function automatic logic [31:0] fmt_uint(input logic [9:0] v);
        return {22'h000000, v};
    endfunction

    task automatic test_done;
        $display("checks %0d mismatches %0d", comparisons, n_mismatch);
        if (n_mismatch == 0 && comparisons > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("[ERR] %s expected %h seen %h", name, exp, seen);
        end
    endtask

    // master holds the request until it samples ack high, then releases
    task automatic wb(input logic we, input logic [5:0] idx, input logic [31:0] d);
        integer k;
        @(posedge clk_i);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= {idx, 2'b00};
        wb_dat_i <= d;
        k = 0;
        do begin
            @(posedge clk_i);
            k++;
        end while (wb_ack_o !== 1'b1 && k < 20);
        q = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        wb_we_i <= 1'b0;
        if (k >= 20) begin
            check("bus timeout", 32'h1, 32'h0);
            test_done();
        end
    endtask

    // bounded wait: 0 irq high, 1 sample high, 2 sample low
    task automatic wait_until(input integer m);
        integer k;
        for (k = 0; k < 3000; k++) begin
            if ((m == 0 ? irq_o : (m == 1 ? sample_o : ~sample_o)) === 1'b1) break;
            @(posedge clk_i);
        end
        if (k >= 3000) begin
            check("wait timeout", m, 32'hffffffff);
            test_done();
        end
    endtask

    initial begin
        clk_i = 1'b0;
        forever #25 clk_i = ~clk_i;
    end

    // ----------------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------------
    initial begin
        seed = 72173;
        n_mismatch = 0;
        comparisons = 0;
        rst_i = 1'b1;
        {wb_cyc_i, wb_stb_i, wb_we_i, trigger_i} = 4'h0;
        wb_adr_i = 8'h00;
        wb_sel_i = 4'h3;
        wb_dat_i = 32'h00000000;
        level = 10'h000;
        repeat (10) @(posedge clk_i);
        rst_i <= 1'b0;
        for (n = 6'h10; n <= 6'h18; n++) begin
            wb(1'b0, n[5:0], 32'h0);
            check("reset value", q, 32'h0);
        end
        wb(1'b0, 6'h3f, 32'h0);
        check("unmapped read", q, 32'h0);
        $display("test reset done");

        r = $random(seed);
        wb(1'b1, `ADC_IDX_PCFG, r);
        repeat (2) @(posedge clk_i);
        check("analog pins", analog_pin_en_o, {16'h0000, ~r[15:0]});
        wb(1'b1, `ADC_IDX_SCAN, r ^ 32'h5a5a);
        wb(1'b0, `ADC_IDX_SCAN, 32'h0);
        check("scan select", q, {16'h0, r[15:0] ^ 16'h5a5a});
        wb(1'b1, `ADC_IDX_CTRL2, 32'h2000);
        repeat (2) @(posedge clk_i);
        check("ref select", ref_ext_o, 1'b1);
        wb(1'b1, `ADC_IDX_CTRL2, 32'h0);
        wb(1'b1, `ADC_IDX_ISEL, r & 32'h0000003f);
        wb(1'b0, `ADC_IDX_ISEL, 32'h0);
        check("input select", q, r & 32'h3f);
        $display("test registers done");

        wb(1'b1, `ADC_IDX_ENABLE, 32'h1);
        for (n = 0; n < 6; n++) begin
            lv = (n == 0) ? 10'h000 : ((n == 1) ? 10'h3ff : 10'($random(seed)));
            level <= lv;
            wb(1'b1, `ADC_IDX_CTRL1, 32'h8002);
            wait_until(1);
            check("ch0 route", ch0_input_o, r[3:0]);
            check("ch123 route", ch123_input_o, r[5:4]);
            check("hold channel", sh_channel_o, 2'h0);
            wb(1'b1, `ADC_IDX_CTRL1, 32'h8000);
            wait_until(0);
            wb(1'b0, 6'h00, 32'h0);
            check("soft result", q, fmt_uint(lv));
            wb(1'b1, 6'h00, $random(seed));
            wb(1'b0, 6'h00, 32'h0);
            check("entry write", q, fmt_uint(lv));
            if (n < 5) begin
                wb(1'b1, `ADC_IDX_CLEAR, 32'h1);
                repeat (3) @(posedge clk_i);
                check("irq cleared", irq_o, 1'b0);
            end
        end
        wb(1'b1, `ADC_IDX_ENABLE, 32'h0);
        repeat (3) @(posedge clk_i);
        check("irq masked", irq_o, 1'b0);
        wb(1'b0, `ADC_IDX_STATUS, 32'h0);
        check("status sticky", q, 32'h1);
        wb(1'b1, `ADC_IDX_CLEAR, 32'h1);
        wb(1'b0, `ADC_IDX_STATUS, 32'h0);
        check("status clear", q, 32'h0);
        $display("test soft conversion done");

        wb(1'b1, `ADC_IDX_CTRL1, 32'h0);
        wb(1'b1, `ADC_IDX_CTRL3, 32'h0009);
        level <= ~lv;
        wb(1'b1, `ADC_IDX_CTRL1, 32'h8002);
        wait_until(1);
        wb(1'b1, `ADC_IDX_CTRL1, 32'h8000);
        wb(1'b1, `ADC_IDX_CTRL1, 32'h0);
        wb(1'b0, `ADC_IDX_STATUS, 32'h0);
        check("abort flag", q, 32'h2);
        wb(1'b0, 6'h00, 32'h0);
        check("abort keeps", q, fmt_uint(lv));
        wb(1'b1, `ADC_IDX_CLEAR, 32'h3);
        repeat (10) @(posedge clk_i);
        $display("test abort done");

        lv = 10'($random(seed));
        lv_b = 10'($random(seed));
        level <= lv;
        wb(1'b1, `ADC_IDX_CTRL3, 32'h0809);
        wb(1'b1, `ADC_IDX_CTRL2, 32'h000c);
        wb(1'b1, `ADC_IDX_ENABLE, 32'h1);
        wb(1'b1, `ADC_IDX_CTRL1, 32'h80e6);
        wait_until(0);
        level <= lv_b;
        wb(1'b1, `ADC_IDX_CLEAR, 32'h1);
        wait_until(2);
        wait_until(1);
        for (n = 0; n < 200 && sample_o === 1'b1; n++) @(posedge clk_i);
        check("auto sample time", n, 32'd40);
        wait_until(0);
        wb(1'b1, `ADC_IDX_CTRL1, 32'h0);
        for (n = 0; n < 5; n++) begin
            wb(1'b0, n[5:0], 32'h0);
            check("auto entry", q, (n < 4) ? fmt_uint(lv_b) : 32'h0);
        end
        wb(1'b1, `ADC_IDX_CTRL1, 32'h0200);
        wb(1'b0, 6'h01, 32'h0);
        check("frac format", q, {16'h0000, lv_b, 6'h00});
        $display("test auto sequence done");

        level <= lv;
        wb(1'b1, `ADC_IDX_CTRL2, 32'h0);
        wb(1'b1, `ADC_IDX_CLEAR, 32'h3);
        wb(1'b1, `ADC_IDX_CTRL1, 32'h8022);
        wait_until(1);
        trigger_i <= 1'b1;
        wait_until(2);
        trigger_i <= 1'b0;
        wait_until(0);
        wb(1'b0, 6'h00, 32'h0);
        check("external trigger", q, fmt_uint(lv));
        $display("test external trigger done");
        test_done();
    end
endmodule

`default_nettype wire
